// ==== hdl/port_pullup_analog_config.sv ====
// The implementer's own choice: the strobed register port.
module port_pullup_analog_config
  import port_cfg_pkg::*;
(
  input wire logic clk,
  input wire logic rst_n,
  input wire logic [ADDR_W-1:0] addr,
  input wire logic [7:0] wr_data,
  input wire logic [7:0] wr_mask,
  input wire logic wr_en,
  input wire logic rd_en,
  output logic [7:0] rd_data,
  input wire logic [7:0] p1_in,
  input wire logic [7:0] p2_in,
  input wire logic [7:0] p3_in,
  input wire logic [7:0] p4_in,
  input wire logic [7:0] p1_alt_out,
  input wire logic [7:0] p3_alt_out,
  input wire logic [7:0] p4_alt_out,
  output logic [7:0] p1_out,
  output logic [7:0] p2_out,
  output logic [7:0] p3_out,
  output logic [7:0] p4_out,
  output logic [7:0] p1_oe,
  output logic [7:0] p2_oe,
  output logic [7:0] p3_oe,
  output logic [7:0] p4_oe,
  output logic [7:0] p1_pullup,
  output logic [7:0] p3_pullup,
  output logic [7:0] p4_pullup,
  output logic p10_analog,
  output logic [7:0] p2_analog
);

  logic [7:0] latch1, latch2, latch3, latch4;
  logic [7:0] next_latch1, next_latch2, next_latch3, next_latch4;
  logic [7:0] dir1, dir2, dir3, dir4;
  logic [7:0] next_dir1, next_dir2, next_dir3, next_dir4;
  logic [7:0] pullup1, pullup3, pullup4;
  logic [7:0] next_pullup1, next_pullup3, next_pullup4;
  logic [7:0] p1_analog_sel, next_p1_analog_sel;
  logic [7:0] analog_cfg, next_analog_cfg;
  logic [7:0] next_rd_data;
  logic [7:0] p1_analog_vec;
  logic [7:0] port_read1, port_read2, port_read3, port_read4;

  // Bit or byte merge under the write mask, then pin unimplemented bits
  function automatic logic [7:0] merge(input logic [7:0] old, input logic [7:0] data,
                                       input logic [7:0] mask, input logic [7:0] ones,
                                       input logic [7:0] zeros);
    logic [7:0] v;
    v = (old & ~mask) | (data & mask);
    merge = (v | ones) & ~zeros;
  endfunction : merge

  // Output mode reads the latch, input mode reads the pin
  function automatic logic [7:0] port_view(input logic [7:0] latch, input logic [7:0] dir,
                                           input logic [7:0] pin);
    port_view = (latch & ~dir) | (pin & dir);
  endfunction : port_view

  assign p1_analog_vec = {7'h00, p1_analog_sel[P10_BIT]};

  assign port_read1 = port_view(latch1, dir1, p1_in);
  assign port_read2 = port_view(latch2, dir2, p2_in) & ~(dir2 & ~analog_cfg);
  assign port_read3 = port_view(latch3, dir3, p3_in);
  assign port_read4 = port_view(latch4, dir4, p4_in);

  // Output latches take writes in either direction mode
  // The pin only shows the latch where the buffer is enabled
  always_comb
  begin
    next_latch1 = latch1;
    next_latch2 = latch2;
    next_latch3 = latch3;
    next_latch4 = latch4;
    if (wr_en)
    begin
      case (addr)
        ADDR_LATCH_P1: next_latch1 = merge(latch1, wr_data, wr_mask, NONE, NONE);
        ADDR_LATCH_P2: next_latch2 = merge(latch2, wr_data, wr_mask, NONE, NONE);
        ADDR_LATCH_P3: next_latch3 = merge(latch3, wr_data, wr_mask, NONE, ZERO_P3);
        ADDR_LATCH_P4: next_latch4 = merge(latch4, wr_data, wr_mask, NONE, ZERO_P4);
        default:
        begin
          next_latch1 = latch1;
        end
      endcase
    end
  end

  always_ff @(posedge clk)
  begin
    if (!rst_n)
    begin
      latch1 <= RST_LATCH;
      latch2 <= RST_LATCH;
      latch3 <= RST_LATCH;
      latch4 <= RST_LATCH;
    end
    else
    begin
      latch1 <= next_latch1;
      latch2 <= next_latch2;
      latch3 <= next_latch3;
      latch4 <= next_latch4;
    end
  end

  // Direction registers; missing pins stay in input mode
  // so a stray write can never switch on a buffer that does not exist
  always_comb
  begin
    next_dir1 = dir1;
    next_dir2 = dir2;
    next_dir3 = dir3;
    next_dir4 = dir4;
    if (wr_en)
    begin
      case (addr)
        ADDR_DIR_P1: next_dir1 = merge(dir1, wr_data, wr_mask, NONE, NONE);
        ADDR_DIR_P2: next_dir2 = merge(dir2, wr_data, wr_mask, NONE, NONE);
        ADDR_DIR_P3: next_dir3 = merge(dir3, wr_data, wr_mask, ONES_DIR_P3, NONE);
        ADDR_DIR_P4: next_dir4 = merge(dir4, wr_data, wr_mask, ONES_DIR_P4, NONE);
        default:
        begin
          next_dir1 = dir1;
        end
      endcase
    end
  end

  always_ff @(posedge clk)
  begin
    if (!rst_n)
    begin
      dir1 <= RST_DIR;
      dir2 <= RST_DIR;
      dir3 <= RST_DIR;
      dir4 <= RST_DIR;
    end
    else
    begin
      dir1 <= next_dir1;
      dir2 <= next_dir2;
      dir3 <= next_dir3;
      dir4 <= next_dir4;
    end
  end

  // Pull-up selects; bit writes arrive as one-hot masks
  always_comb
  begin
    next_pullup1 = pullup1;
    next_pullup3 = pullup3;
    next_pullup4 = pullup4;
    if (wr_en)
    begin
      case (addr)
        ADDR_PULLUP_P1: next_pullup1 = merge(pullup1, wr_data, wr_mask, NONE, NONE);
        ADDR_PULLUP_P3: next_pullup3 = merge(pullup3, wr_data, wr_mask, NONE, ZERO_P3);
        ADDR_PULLUP_P4: next_pullup4 = merge(pullup4, wr_data, wr_mask, NONE, ZERO_P4);
        default:
        begin
          next_pullup1 = pullup1;
        end
      endcase
    end
  end

  always_ff @(posedge clk)
  begin
    if (!rst_n)
    begin
      pullup1 <= RST_PULLUP;
      pullup3 <= RST_PULLUP;
      pullup4 <= RST_PULLUP_P4;
    end
    else
    begin
      pullup1 <= next_pullup1;
      pullup3 <= next_pullup3;
      pullup4 <= next_pullup4;
    end
  end

  // Analog selection for P10 and the port-2 converter pins
  always_comb
  begin
    next_p1_analog_sel = p1_analog_sel;
    next_analog_cfg = analog_cfg;
    if (wr_en)
    begin
      case (addr)
        ADDR_P1_ANALOG:
          next_p1_analog_sel = merge(p1_analog_sel, wr_data, wr_mask,
                                     ONES_P1_ANALOG, NONE);
        ADDR_ANALOG_CFG:
        begin
          // Partial writes are dropped, not merged
          if (wr_mask == FULL_BYTE)
          begin
            next_analog_cfg = wr_data;
          end
        end
        default:
        begin
          next_analog_cfg = analog_cfg;
        end
      endcase
    end
  end

  always_ff @(posedge clk)
  begin
    if (!rst_n)
    begin
      p1_analog_sel <= RST_P1_ANALOG;
      analog_cfg <= RST_ANALOG_CFG;
    end
    else
    begin
      p1_analog_sel <= next_p1_analog_sel;
      analog_cfg <= next_analog_cfg;
    end
  end

  // Read data stands in the cycle after the strobe; reads change no state
  always_comb
  begin
    next_rd_data = READ_IDLE;
    if (rd_en)
    begin
      case (addr)
        ADDR_LATCH_P1: next_rd_data = port_read1;
        ADDR_LATCH_P2: next_rd_data = port_read2;
        ADDR_LATCH_P3: next_rd_data = port_read3;
        ADDR_LATCH_P4: next_rd_data = port_read4;
        ADDR_DIR_P1: next_rd_data = dir1;
        ADDR_DIR_P2: next_rd_data = dir2;
        ADDR_DIR_P3: next_rd_data = dir3;
        ADDR_DIR_P4: next_rd_data = dir4;
        ADDR_PULLUP_P1: next_rd_data = pullup1;
        ADDR_PULLUP_P3: next_rd_data = pullup3;
        ADDR_PULLUP_P4: next_rd_data = pullup4;
        ADDR_P1_ANALOG: next_rd_data = p1_analog_sel;
        ADDR_ANALOG_CFG: next_rd_data = analog_cfg;
        default: next_rd_data = READ_IDLE;
      endcase
    end
  end

  // Read data falls back to zero in any cycle without a taken read
  always_ff @(posedge clk)
  begin
    if (!rst_n)
    begin
      rd_data <= READ_IDLE;
    end
    else
    begin
      rd_data <= next_rd_data;
    end
  end

  // Pin drivers: latch always presented, buffer on only for direction zero
  assign p1_out = latch1;
  assign p2_out = latch2;
  assign p3_out = latch3;
  assign p4_out = latch4;
  assign p1_oe = ~dir1;
  assign p2_oe = ~dir2;
  assign p3_oe = ~dir3;
  assign p4_oe = ~dir4;

  // Analog routing towards the converter
  assign p10_analog = p1_analog_sel[P10_BIT];
  assign p2_analog = ~analog_cfg;

  // Pull-up only on input-mode pins that are neither analog nor driving an alternate output
  assign p1_pullup = pullup1 & dir1 & ~p1_alt_out & ~p1_analog_vec;
  assign p3_pullup = pullup3 & dir3 & ~p3_alt_out;
  assign p4_pullup = pullup4 & dir4 & ~p4_alt_out;

endmodule : port_pullup_analog_config

// ==== hdl/port_cfg_pkg.sv ====
package port_cfg_pkg;

  localparam int ADDR_W = 20;

  // Register byte addresses
  localparam logic [ADDR_W-1:0] ADDR_LATCH_P1 = 20'hF_FF01;
  localparam logic [ADDR_W-1:0] ADDR_LATCH_P2 = 20'hF_FF02;
  localparam logic [ADDR_W-1:0] ADDR_LATCH_P3 = 20'hF_FF03;
  localparam logic [ADDR_W-1:0] ADDR_LATCH_P4 = 20'hF_FF04;
  localparam logic [ADDR_W-1:0] ADDR_DIR_P1 = 20'hF_FF21;
  localparam logic [ADDR_W-1:0] ADDR_DIR_P2 = 20'hF_FF22;
  localparam logic [ADDR_W-1:0] ADDR_DIR_P3 = 20'hF_FF23;
  localparam logic [ADDR_W-1:0] ADDR_DIR_P4 = 20'hF_FF24;
  localparam logic [ADDR_W-1:0] ADDR_PULLUP_P1 = 20'hF_0031;
  localparam logic [ADDR_W-1:0] ADDR_PULLUP_P3 = 20'hF_0033;
  localparam logic [ADDR_W-1:0] ADDR_PULLUP_P4 = 20'hF_0034;
  localparam logic [ADDR_W-1:0] ADDR_P1_ANALOG = 20'hF_0061;
  localparam logic [ADDR_W-1:0] ADDR_ANALOG_CFG = 20'hF_0076;

  // Reset values
  localparam logic [7:0] RST_LATCH = 8'h00;
  localparam logic [7:0] RST_DIR = 8'hFF;
  localparam logic [7:0] RST_PULLUP = 8'h00;
  localparam logic [7:0] RST_PULLUP_P4 = 8'h01;
  localparam logic [7:0] RST_P1_ANALOG = 8'hFF;
  localparam logic [7:0] RST_ANALOG_CFG = 8'h00;

  // Bits that are not implemented: forced to one or to zero
  localparam logic [7:0] NONE = 8'h00;
  localparam logic [7:0] ONES_DIR_P3 = 8'hC0;
  localparam logic [7:0] ONES_DIR_P4 = 8'hFE;
  localparam logic [7:0] ZERO_P3 = 8'hC0;
  localparam logic [7:0] ZERO_P4 = 8'hFE;
  localparam logic [7:0] ONES_P1_ANALOG = 8'hFE;

  localparam logic [7:0] FULL_BYTE = 8'hFF;
  localparam logic [7:0] READ_IDLE = 8'h00;
  localparam int P10_BIT = 0;

endpackage : port_cfg_pkg

// ==== testbench/port_cfg_checker.sv ====
module port_cfg_checker
  import port_cfg_pkg::*;
(
  input wire logic clk,
  input wire logic rst_n,
  input wire logic [ADDR_W-1:0] addr,
  input wire logic [7:0] wr_data,
  input wire logic [7:0] wr_mask,
  input wire logic wr_en,
  input wire logic rd_en,
  input wire logic [7:0] rd_data,
  input wire logic [7:0] p1_in,
  input wire logic [7:0] p1_alt_out,
  input wire logic [7:0] p4_alt_out,
  input wire logic [7:0] p1_out,
  input wire logic [7:0] p1_oe,
  input wire logic [7:0] p1_pullup,
  input wire logic [7:0] p4_pullup,
  input wire logic p10_analog,
  input wire logic [7:0] p2_analog
);
  timeunit 1ns;
  timeprecision 1ps;
  default clocking cb @(posedge clk);
  endclocking
  default disable iff (!rst_n);
  property p_no_pu; (p1_pullup & (p1_oe | p1_alt_out)) == 8'h00; endproperty
  a_no_pu: assert property (p_no_pu) else $error("pull-up on driven pin");
  property p_rst; disable iff (1'b0) !rst_n |=> p1_out == 8'h00 && p1_oe == 8'h00
    && p10_analog && p2_analog == 8'hFF; endproperty
  a_rst: assert property (p_rst) else $error("bad reset state");
  property p_pu4; disable iff (1'b0) !rst_n && !p4_alt_out[0] |=> p4_pullup == 8'h01;
  endproperty
  a_pu4: assert property (p_pu4) else $error("port 4 pull-up reset");
  property p_wr; wr_en && addr == ADDR_LATCH_P1 && wr_mask == 8'hFF |=> p1_out == $past(wr_data);
  endproperty
  a_wr: assert property (p_wr) else $error("latch write lost");
  property p_dir; wr_en && addr == ADDR_DIR_P1 && wr_mask == 8'hFF |=> p1_oe == ~$past(wr_data);
  endproperty
  a_dir: assert property (p_dir) else $error("buffer enable wrong");
  property p_part; wr_en && addr == ADDR_ANALOG_CFG && wr_mask != 8'hFF |=> $stable(p2_analog);
  endproperty
  a_part: assert property (p_part) else $error("partial config write taken");
  property p_rd; rd_en && addr == ADDR_LATCH_P1 |=> rd_data ==
    (($past(p1_out) & $past(p1_oe)) | ($past(p1_in) & ~$past(p1_oe))); endproperty
  a_rd: assert property (p_rd) else $error("port read wrong");
  property p_keep; rd_en |=> $stable(p1_out); endproperty
  a_keep: assert property (p_keep) else $error("read altered latch");
  c_rd: cover property (rd_en && addr == ADDR_LATCH_P1);
  c_pu: cover property (p1_pullup != 8'h00);
  c_cfg: cover property (wr_en && addr == ADDR_ANALOG_CFG);
endmodule : port_cfg_checker

// ==== testbench/tb.sv ====
module tb
  import port_cfg_pkg::*;
;
  timeunit 1ns;
  timeprecision 1ps;
  logic clk = 1'b0, rst_n = 1'b0, wr_en = 1'b0, rd_en = 1'b0, p10_analog;
  logic [ADDR_W-1:0] addr = '0;
  logic [7:0] wr_data = 8'h00, wr_mask = 8'h00, p1_in = 8'h00, p2_in = 8'h00, p3_in = 8'h00;
  logic [7:0] p4_in = 8'h00, p1_alt_out = 8'h00, p3_alt_out = 8'h00, p4_alt_out = 8'h00;
  logic [7:0] rd_data, p1_out, p2_out, p3_out, p4_out, p1_oe, p2_oe, p3_oe, p4_oe;
  logic [7:0] p1_pullup, p3_pullup, p4_pullup, p2_analog;
  int num_errors = 0, comparisons = 0, cycles = 0;
  port_pullup_analog_config u_dut (.clk, .rst_n, .addr, .wr_data, .wr_mask, .wr_en, .rd_en,
    .rd_data, .p1_in, .p2_in, .p3_in, .p4_in, .p1_alt_out, .p3_alt_out, .p4_alt_out, .p1_out,
    .p2_out, .p3_out, .p4_out, .p1_oe, .p2_oe, .p3_oe, .p4_oe, .p1_pullup, .p3_pullup,
    .p4_pullup, .p10_analog, .p2_analog);
  initial forever #4 clk = ~clk;
  task automatic chk(input string n, input logic [7:0] e, input logic [7:0] g);
    comparisons++;
    if (g !== e)
    begin
      num_errors++;
      $display("[ERR] %s expected %h seen %h", n, e, g);
    end
  endtask : chk
  task automatic wr(input logic [ADDR_W-1:0] a, input logic [7:0] d, input logic [7:0] m);
    addr <= a;
    wr_data <= d;
    wr_mask <= m;
    wr_en <= 1'b1;
    @(posedge clk);
    wr_en <= 1'b0;
    @(posedge clk);
  endtask : wr
  task automatic rd(input logic [ADDR_W-1:0] a, input logic [7:0] e, input string n);
    addr <= a;
    rd_en <= 1'b1;
    @(posedge clk);
    rd_en <= 1'b0;
    #1 chk(n, e, rd_data);
    @(posedge clk);
  endtask : rd
  task automatic t_reset;
    rd(ADDR_PULLUP_P1, 8'h00, "pu1");
    rd(ADDR_PULLUP_P3, 8'h00, "pu3");
    rd(ADDR_PULLUP_P4, 8'h01, "pu4");
    rd(ADDR_P1_ANALOG, 8'hFF, "p1 analog");
    rd(ADDR_ANALOG_CFG, 8'h00, "cfg");
    rd(20'h0_0000, 8'h00, "unmapped");
    chk("p4_pullup", 8'h01, p4_pullup);
    chk("p2_out", 8'h00, p2_out);
    $display("test reset done");
  endtask : t_reset
  task automatic t_pullup;
    p1_alt_out <= 8'h80;
    wr(ADDR_DIR_P1, 8'hF1, 8'hFF);
    wr(ADDR_PULLUP_P1, 8'hFF, 8'hFF);
    chk("p1_pullup", 8'h70, p1_pullup);
    wr(ADDR_PULLUP_P1, 8'h00, 8'h10);
    chk("p1_pullup bit", 8'h60, p1_pullup);
    wr(ADDR_P1_ANALOG, 8'h00, 8'h01);
    chk("p1_pullup digital", 8'h61, p1_pullup);
    chk("p10_analog", 8'h00, {7'h00, p10_analog});
    rd(ADDR_P1_ANALOG, 8'hFE, "p1 analog");
    p1_alt_out <= 8'h00;
    $display("test pullup done");
  endtask : t_pullup
  task automatic t_latch;
    p1_in <= 8'h3C;
    wr(ADDR_DIR_P1, 8'hF0, 8'hFF);
    wr(ADDR_LATCH_P1, 8'hA5, 8'hFF);
    chk("p1_oe", 8'h0F, p1_oe);
    rd(ADDR_LATCH_P1, 8'h35, "p1 read");
    wr(ADDR_LATCH_P1, 8'h35 ^ 8'h0F, 8'hFF);
    chk("p1_out", 8'h3A, p1_out);
    wr(ADDR_LATCH_P2, 8'h55, 8'hFF);
    chk("p2_out", 8'h55, p2_out);
    chk("p2_oe", 8'h00, p2_oe);
    $display("test latch done");
  endtask : t_latch
  task automatic t_analog;
    p2_in <= 8'hFF;
    wr(ADDR_DIR_P2, 8'hFF, 8'hFF);
    wr(ADDR_ANALOG_CFG, 8'hFF, 8'h0F);
    chk("p2_analog part", 8'hFF, p2_analog);
    wr(ADDR_ANALOG_CFG, 8'hFC, 8'hFF);
    chk("p2_analog", 8'h03, p2_analog);
    rd(ADDR_LATCH_P2, 8'hFC, "p2 read");
    $display("test analog done");
  endtask : t_analog
  task automatic t_port34;
    p3_alt_out <= 8'h04;
    wr(ADDR_DIR_P3, 8'hC5, 8'hFF);
    wr(ADDR_LATCH_P3, 8'h3F, 8'hFF);
    wr(ADDR_PULLUP_P3, 8'h3F, 8'hFF);
    chk("p3_oe", 8'h3A, p3_oe);
    chk("p3_out", 8'h3F, p3_out);
    chk("p3_pullup", 8'h01, p3_pullup);
    rd(ADDR_LATCH_P3, 8'h3A, "p3 read");
    wr(ADDR_DIR_P4, 8'hFE, 8'hFF);
    wr(ADDR_LATCH_P4, 8'h01, 8'hFF);
    chk("p4_oe", 8'h01, p4_oe);
    chk("p4_out", 8'h01, p4_out);
    chk("p4_pullup out", 8'h00, p4_pullup);
    p3_alt_out <= 8'h00;
    $display("test port34 done");
  endtask : t_port34
  task automatic t_rereset;
    rst_n <= 1'b0;
    repeat (2) @(posedge clk);
    rst_n <= 1'b1;
    @(posedge clk);
    chk("p1_out rst", 8'h00, p1_out);
    chk("p3_out rst", 8'h00, p3_out);
    chk("p4_oe rst", 8'h00, p4_oe);
    chk("p4_pullup rst", 8'h01, p4_pullup);
    chk("p2_analog rst", 8'hFF, p2_analog);
    rd(ADDR_P1_ANALOG, 8'hFF, "p1 analog rst");
    $display("test rereset done");
  endtask : t_rereset
  task automatic complete_run;
    $display("checks %0d errors %0d", comparisons, num_errors);
    if (num_errors == 0 && comparisons > 0)
      $display("ALL TESTS PASSED");
    else
      $display("TESTS FAILED");
    $finish;
  endtask : complete_run
  always @(posedge clk)
  begin
    cycles++;
    if (cycles == 2000)
    begin
      num_errors++;
      complete_run();
    end
  end
  initial
  begin
    repeat (8) @(posedge clk);
    rst_n <= 1'b1;
    @(posedge clk);
    t_reset();
    t_pullup();
    t_latch();
    t_port34();
    t_analog();
    t_rereset();
    complete_run();
  end
endmodule : tb
bind port_pullup_analog_config port_cfg_checker u_chk (.clk, .rst_n, .addr, .wr_data, .wr_mask,
  .wr_en, .rd_en, .rd_data, .p1_in, .p1_alt_out, .p4_alt_out, .p1_out, .p1_oe, .p1_pullup,
  .p4_pullup, .p10_analog, .p2_analog);
